// ---- src/pin_mux.v ----
// Flag/GPIO multiplexer for twelve multipurpose pins in groups A, B and C.
// Assumes flags come from logic on clock_i; pin inputs are asynchronous.
// Pin index: 3..0 group A, 7..4 group B, 11..8 group C.

`include "pin_mux_map.vh"

module pin_mux #(
    parameter PIN_COUNT = 12
) (
    input  wire                 clock_i,
    input  wire                 reset_n_i,
    input  wire                 clk_en_i,
    input  wire [`ADDR_W-1:0]   addr_i,
    input  wire [`DATA_W-1:0]   wdata_i,
    input  wire                 wr_i,
    input  wire                 rd_i,
    output wire [`DATA_W-1:0]   rdata_o,
    input  wire                 clock_status_flag_i,
    input  wire                 deemphasis_flag_i,
    input  wire                 burst_preamble_sync_i,
    input  wire                 compressed_cd_detect_i,
    input  wire                 parity_error_i,
    input  wire                 receiver_lock_i,
    input  wire                 validity_bit_out_i,
    input  wire                 user_bit_out_i,
    input  wire                 channel_status_bit_out_i,
    input  wire                 block_start_marker_i,
    input  wire [3:0]           sample_rate_code_i,
    input  wire                 interrupt_line_zero_i,
    input  wire                 interrupt_line_one_i,
    input  wire [PIN_COUNT-1:0] pin_in_i,
    output wire [PIN_COUNT-1:0] pin_out_o,
    output wire [PIN_COUNT-1:0] pin_oe_o,
    output wire [1:0]           multichannel_route_source_o
);

    // Pick one flag out of sixteen by code
    function flag_pick;
        input [15:0]             vec;
        input [`FLAG_CODE_W-1:0] code;
        begin
            flag_pick = vec[code];
        end
    endfunction

    // Nibble of a selector register for a pin
    function [`FLAG_CODE_W-1:0] nibble_of;
        input [`DATA_W-1:0] value;
        input               upper;
        begin
            if (upper) begin
                nibble_of = value[7:4];
            end else begin
                nibble_of = value[3:0];
            end
        end
    endfunction

    reg  [`DATA_W-1:0] group_function_r;
    reg  [`DATA_W-1:0] group_a_assign_r;
    reg  [`DATA_W-1:0] group_b_c_assign_r;
    reg  [`DATA_W-1:0] flag_select_r [0:`FLAG_SELECT_COUNT-1];
    reg  [`DATA_W-1:0] gpio_dir_a_b_r;
    reg  [3:0]         gpio_dir_c_r;
    reg  [`DATA_W-1:0] gpio_out_a_b_r;
    reg  [3:0]         gpio_out_c_r;
    reg  [`DATA_W-1:0] rdata_r;
    reg  [`DATA_W-1:0] rdata_nxt;
    reg  [PIN_COUNT-1:0] pin_meta_r;
    reg  [PIN_COUNT-1:0] pin_sync_r;
    reg  [PIN_COUNT-1:0] pin_out_r;
    reg  [PIN_COUNT-1:0] pin_oe_r;
    wire [PIN_COUNT-1:0] pin_out_nxt;
    wire [PIN_COUNT-1:0] pin_oe_nxt;
    wire [PIN_COUNT-1:0] pin_is_gpio;
    wire [PIN_COUNT-1:0] gpio_dir;
    wire [PIN_COUNT-1:0] gpio_out;
    wire [PIN_COUNT-1:0] group_mode;
    wire [15:0]          flag_vec;
    wire                 mode_one;
    wire                 mode_two;
    wire                 mode_three;
    wire                 sel_hit;
    integer              i;

    // Bit k is the flag of code k
    assign flag_vec = {interrupt_line_one_i,
                       interrupt_line_zero_i,
                       sample_rate_code_i[3],
                       sample_rate_code_i[2],
                       sample_rate_code_i[1],
                       sample_rate_code_i[0],
                       block_start_marker_i,
                       channel_status_bit_out_i,
                       user_bit_out_i,
                       validity_bit_out_i,
                       receiver_lock_i,
                       parity_error_i,
                       compressed_cd_detect_i,
                       burst_preamble_sync_i,
                       deemphasis_flag_i,
                       clock_status_flag_i};

    assign mode_one = (group_function_r[`GROUP_ONE_FIELD_HI:`GROUP_ONE_FIELD_LO]
                       == `GROUP_ONE_FLAG_GPIO);
    assign mode_two = (group_function_r[`GROUP_TWO_FIELD_HI:`GROUP_TWO_FIELD_LO]
                       == `GROUP_TWO_FLAG_GPIO);
    assign mode_three = (group_function_r[`GROUP_THREE_FIELD_HI:`GROUP_THREE_FIELD_LO]
                         == `GROUP_THREE_FLAG_GPIO);
    assign group_mode = {{4{mode_three}}, {4{mode_two}}, {4{mode_one}}};

    // Flag or GPIO bit per pin
    assign pin_is_gpio = {group_b_c_assign_r[3:0],
                          group_b_c_assign_r[7:4],
                          group_a_assign_r[3:0]};
    assign gpio_dir = {gpio_dir_c_r, gpio_dir_a_b_r};
    assign gpio_out = {gpio_out_c_r, gpio_out_a_b_r};

    genvar p;
    generate
        for (p = 0; p < PIN_COUNT; p = p + 1) begin : g_pin
            // Group A keys all four selectors on A3/A2 only, unlike B and C
            localparam PAIR_HI = (p < 4) ? 3 : (p | 1);
            localparam PAIR_LO = (p < 4) ? 2 : (p & ~1);
            wire [`FLAG_CODE_W-1:0] code;
            wire                    pair_ok;
            wire                    flag_on;
            wire                    gpio_on;
            // Pin p uses register p/2, odd pins the upper nibble
            assign code = nibble_of(flag_select_r[p/2], (p % 2) == 1);
            assign pair_ok = ~pin_is_gpio[PAIR_HI] & ~pin_is_gpio[PAIR_LO];
            assign flag_on = group_mode[p] & ~pin_is_gpio[p] & pair_ok;
            assign gpio_on = group_mode[p] & pin_is_gpio[p];
            assign pin_oe_nxt[p] = flag_on | (gpio_on & gpio_dir[p]);
            assign pin_out_nxt[p] = flag_on ? flag_pick(flag_vec, code) :
                                    (gpio_on & gpio_dir[p] & gpio_out[p]);
        end
    endgenerate

    // Registers, pin outputs and input synchroniser
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            group_function_r   <= `RST_GROUP_FUNCTION;
            group_a_assign_r   <= `RST_GROUP_A_ASSIGN;
            group_b_c_assign_r <= `RST_GROUP_B_C_ASSIGN;
            for (i = 0; i < `FLAG_SELECT_COUNT; i = i + 1) begin
                flag_select_r[i] <= `RST_FLAG_SELECT;
            end
            gpio_dir_a_b_r <= `RST_GPIO_DIR;
            gpio_dir_c_r   <= 4'h0;
            gpio_out_a_b_r <= `RST_GPIO_OUT;
            gpio_out_c_r   <= 4'h0;
            rdata_r        <= 8'h00;
            pin_meta_r     <= {PIN_COUNT{1'b0}};
            pin_sync_r     <= {PIN_COUNT{1'b0}};
            pin_out_r      <= {PIN_COUNT{1'b0}};
            pin_oe_r       <= {PIN_COUNT{1'b0}};
        end else if (clk_en_i) begin
            pin_meta_r <= pin_in_i;
            pin_sync_r <= pin_meta_r;
            // Single retiming stage; new settings show one edge after the write
            pin_out_r  <= pin_out_nxt;
            pin_oe_r   <= pin_oe_nxt;
            rdata_r    <= rdata_nxt;
            if (wr_i) begin
                case (addr_i)
                    `OFS_GROUP_FUNCTION: begin
                        group_function_r <= wdata_i;
                    end
                    `OFS_GROUP_A_ASSIGN: begin
                        group_a_assign_r <= wdata_i & `GROUP_A_ASSIGN_MASK;
                    end
                    `OFS_GROUP_B_C_ASSIGN: begin
                        group_b_c_assign_r <= wdata_i;
                    end
                    `OFS_PIN_A1_A0_SELECT: begin
                        flag_select_r[0] <= wdata_i;
                    end
                    `OFS_PIN_A3_A2_SELECT: begin
                        flag_select_r[1] <= wdata_i;
                    end
                    `OFS_PIN_B1_B0_SELECT: begin
                        flag_select_r[2] <= wdata_i;
                    end
                    `OFS_PIN_B3_B2_SELECT: begin
                        flag_select_r[3] <= wdata_i;
                    end
                    `OFS_PIN_C1_C0_SELECT: begin
                        flag_select_r[4] <= wdata_i;
                    end
                    `OFS_PIN_C3_C2_SELECT: begin
                        flag_select_r[5] <= wdata_i;
                    end
                    `OFS_GPIO_DIR_A_B: begin
                        gpio_dir_a_b_r <= wdata_i;
                    end
                    `OFS_GPIO_DIR_C: begin
                        gpio_dir_c_r <= wdata_i[3:0];
                    end
                    `OFS_GPIO_OUT_A_B: begin
                        gpio_out_a_b_r <= wdata_i;
                    end
                    `OFS_GPIO_OUT_C: begin
                        gpio_out_c_r <= wdata_i[3:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    assign sel_hit = (addr_i >= `OFS_PIN_A1_A0_SELECT) &&
                     (addr_i <= `OFS_PIN_C3_C2_SELECT);

    // Read data only in the cycle after the strobe, zero otherwise
    always @* begin
        rdata_nxt = 8'h00;
        if (rd_i) begin
            if (sel_hit) begin
                rdata_nxt = flag_select_r[addr_i[2:0] - 3'h2];
            end else begin
                case (addr_i)
                    `OFS_GROUP_FUNCTION:   rdata_nxt = group_function_r;
                    `OFS_GROUP_A_ASSIGN:   rdata_nxt = group_a_assign_r;
                    `OFS_GROUP_B_C_ASSIGN: rdata_nxt = group_b_c_assign_r;
                    `OFS_GPIO_DIR_A_B:     rdata_nxt = gpio_dir_a_b_r;
                    `OFS_GPIO_DIR_C:       rdata_nxt = {4'h0, gpio_dir_c_r};
                    `OFS_GPIO_OUT_A_B:     rdata_nxt = gpio_out_a_b_r;
                    `OFS_GPIO_OUT_C:       rdata_nxt = {4'h0, gpio_out_c_r};
                    `OFS_GPIO_IN_A_B:      rdata_nxt = pin_sync_r[7:0];
                    `OFS_GPIO_IN_C:        rdata_nxt = {4'h0, pin_sync_r[11:8]};
                    default:               rdata_nxt = 8'h00;
                endcase
            end
        end
    end

    assign rdata_o   = rdata_r;
    assign pin_out_o = pin_out_r;
    assign pin_oe_o  = pin_oe_r;
    // Taken straight from the stored field; routing table lives elsewhere
    assign multichannel_route_source_o =
        group_a_assign_r[`ROUTE_SOURCE_HI:`ROUTE_SOURCE_LO];

endmodule // pin_mux

// ---- include/pin_mux_map.vh ----
// Register map and constants for the multipurpose pin multiplexer.
// Assumes byte-wide registers on an 8-bit control port address.
`ifndef PIN_MUX_MAP_VH
`define PIN_MUX_MAP_VH

`define ADDR_W                 8
`define DATA_W                 8

`define OFS_GROUP_FUNCTION     8'h6f
`define OFS_GROUP_A_ASSIGN     8'h70
`define OFS_GROUP_B_C_ASSIGN   8'h71
`define OFS_PIN_A1_A0_SELECT   8'h72
`define OFS_PIN_A3_A2_SELECT   8'h73
`define OFS_PIN_B1_B0_SELECT   8'h74
`define OFS_PIN_B3_B2_SELECT   8'h75
`define OFS_PIN_C1_C0_SELECT   8'h76
`define OFS_PIN_C3_C2_SELECT   8'h77
`define OFS_GPIO_DIR_A_B       8'h79
`define OFS_GPIO_DIR_C         8'h7a
`define OFS_GPIO_OUT_A_B       8'h7b
`define OFS_GPIO_OUT_C         8'h7c
`define OFS_GPIO_IN_A_B        8'h7d
`define OFS_GPIO_IN_C          8'h7e

`define RST_GROUP_FUNCTION     8'h40
`define RST_GROUP_A_ASSIGN     8'h00
`define RST_GROUP_B_C_ASSIGN   8'h00
`define RST_FLAG_SELECT        8'h00
`define RST_GPIO_DIR           8'h00
`define RST_GPIO_OUT           8'h00

`define GROUP_ONE_FIELD_HI     7
`define GROUP_ONE_FIELD_LO     6
`define GROUP_TWO_FIELD_HI     5
`define GROUP_TWO_FIELD_LO     3
`define GROUP_THREE_FIELD_HI   2
`define GROUP_THREE_FIELD_LO   0
`define GROUP_ONE_FLAG_GPIO    2'h3
`define GROUP_TWO_FLAG_GPIO    3'h3
`define GROUP_THREE_FLAG_GPIO  3'h3

`define ROUTE_SOURCE_HI        5
`define ROUTE_SOURCE_LO        4
`define GROUP_A_ASSIGN_MASK    8'h3f
`define NIBBLE_MASK            8'h0f

`define FLAG_SELECT_COUNT      6
`define FLAG_CODE_W            4

`endif

// ---- dv/flag_host.sv ----
// Host model on the far side of the multipurpose pins.
// Assumes the bench sets host levels by non-blocking assignment.
module flag_host (
    input  wire logic [11:0] host_lvl_i,
    input  wire logic [11:0] pin_out_i,
    input  wire logic [11:0] pin_oe_i,
    output wire logic [11:0] pin_lvl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Host lets go of every driven pin, so no contention is modelled
    assign pin_lvl_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & host_lvl_i);
endmodule // flag_host

// ---- dv/pin_mux_chk.sv ----
// Checker for the pin multiplexer, bound to its ports.
// Assumes shadow copies of the written registers track the design.
module pin_mux_chk #(
    parameter PIN_COUNT = 12
) (
    input wire                 clock_i,
    input wire                 reset_n_i,
    input wire                 clk_en_i,
    input wire [7:0]           addr_i,
    input wire [7:0]           wdata_i,
    input wire                 wr_i,
    input wire                 clock_status_flag_i,
    input wire [PIN_COUNT-1:0] pin_out_o,
    input wire [PIN_COUNT-1:0] pin_oe_o,
    input wire [1:0]           multichannel_route_source_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] fn_r, a_r, b_r, s_r, d_r, o_r;
    wire        wen = wr_i && clk_en_i;
    wire        a_on = fn_r[7:6] == 2'h3;
    wire        b_on = fn_r[5:3] == 3'h3;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fn_r <= 8'h40;
            {a_r, b_r, s_r, d_r, o_r} <= '0;
        end else if (wen) begin
            case (addr_i)
                8'h6f: fn_r <= wdata_i;
                8'h70: a_r <= wdata_i;
                8'h71: b_r <= wdata_i;
                8'h72: s_r <= wdata_i;
                8'h79: d_r <= wdata_i;
                8'h7b: o_r <= wdata_i;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);
    // Pin outputs lag registers by one stage, hence the past values
    AST_RST_FREE: assert property ($rose(reset_n_i) |-> pin_oe_o == '0)
        else $error("pin driven after reset");
    AST_A_GATE: assert property (|pin_oe_o[3:0] |-> $past(a_on))
        else $error("group A driven outside mode");
    AST_B_GATE: assert property (|pin_oe_o[7:4] |-> $past(b_on))
        else $error("group B driven outside mode");
    AST_A_PAIR: assert property (pin_oe_o[0] && !$past(a_r[0]) |-> $past(a_r[3:2]) == 2'h0)
        else $error("A0 flag without pair");
    AST_B_PAIR: assert property (pin_oe_o[4] && !$past(b_r[4]) |-> !$past(b_r[5]))
        else $error("B0 flag without pair");
    AST_FLAG: assert property ($past(a_on && a_r[3:0] == 4'h0 && s_r[3:0] == 4'h0)
        |-> pin_oe_o[0] && pin_out_o[0] == $past(clock_status_flag_i))
        else $error("A0 flag path");
    AST_GPIO: assert property ($past(a_on && a_r[1]) |-> pin_oe_o[1] == $past(d_r[1])
        && pin_out_o[1] == $past(d_r[1] && o_r[1]))
        else $error("A1 gpio drive");
    AST_ROUTE: assert property (wen && addr_i == 8'h70
        |=> multichannel_route_source_o == $past(wdata_i[5:4]))
        else $error("route field");
    cover property (pin_oe_o[3:0] == 4'hf);
    cover property (pin_oe_o[1] && $past(a_r[1]));
    cover property (|pin_oe_o[11:8]);
endmodule // pin_mux_chk

bind pin_mux pin_mux_chk #(.PIN_COUNT(PIN_COUNT)) u_chk (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .clock_status_flag_i(clock_status_flag_i), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o), .multichannel_route_source_o(multichannel_route_source_o)
);

// ---- dv/pin_mux_tb_top.sv ----
// Top bench for the pin multiplexer with host model and checker.
// Assumes a 100 MHz clock; clock enable dropped once to test the freeze.
module pin_mux_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        wr_i = 1'b0, rd_i = 1'b0;
    logic        clk_en = 1'b1;
    logic [7:0]  addr_i = 8'h00, wdata_i = 8'h00;
    logic [15:0] fv = 16'h0000;
    logic [11:0] host_lvl = 12'h000;
    wire  [7:0]  rdata_o;
    wire  [11:0] pin_out_o, pin_oe_o, pin_lvl;
    wire  [1:0]  route;
    int          err_total = 0, num_checks = 0, cyc = 0;
    always #5 clock_i = ~clock_i;
    pin_mux dut (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .clock_status_flag_i(fv[0]), .deemphasis_flag_i(fv[1]),
        .burst_preamble_sync_i(fv[2]), .compressed_cd_detect_i(fv[3]),
        .parity_error_i(fv[4]), .receiver_lock_i(fv[5]), .validity_bit_out_i(fv[6]),
        .user_bit_out_i(fv[7]), .channel_status_bit_out_i(fv[8]),
        .block_start_marker_i(fv[9]), .sample_rate_code_i(fv[13:10]),
        .interrupt_line_zero_i(fv[14]), .interrupt_line_one_i(fv[15]),
        .pin_in_i(pin_lvl), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
        .multichannel_route_source_o(route)
    );
    flag_host host (.host_lvl_i(host_lvl), .pin_out_i(pin_out_o),
        .pin_oe_i(pin_oe_o), .pin_lvl_o(pin_lvl));
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask
    // Flags change at one edge, pins must follow at the very next
    task automatic step(input logic [15:0] v, input logic [11:0] oe, input logic [11:0] out);
        @(posedge clock_i);
        fv <= v;
        @(posedge clock_i);
        #1 chk(pin_oe_o, oe);
        chk(pin_out_o, out);
    endtask
    task automatic t_defaults;
        chk(pin_oe_o, 12'h000);
        rd(8'h6f, 8'h40);
        for (int i = 0; i < 8; i++) rd(8'h70 + i[7:0], 8'h00);
        for (int i = 0; i < 6; i++) wr(8'h72 + i[7:0], 8'h1e * (i[7:0] + 8'h01));
        for (int i = 0; i < 6; i++) rd(8'h72 + i[7:0], 8'h1e * (i[7:0] + 8'h01));
        wr(8'h70, 8'hff);
        #1 chk(route, 2'h3);
        rd(8'h70, 8'h3f);
        wr(8'h80, 8'h55);
        rd(8'h80, 8'h00);
    endtask
    task automatic t_flags;
        wr(8'h70, 8'h00);
        wr(8'h6f, 8'hc0);
        for (int c = 0; c < 16; c++) begin
            wr(8'h72, {c[3:0], c[3:0]});
            wr(8'h73, {c[3:0], c[3:0]});
            step(16'h0001 << c, 12'h00f, 12'h00f);
            step(~(16'h0001 << c), 12'h00f, 12'h000);
        end
    endtask
    task automatic t_gpio;
        wr(8'h70, 8'h06);
        step(16'hffff, 12'h000, 12'h000);
        wr(8'h79, 8'h06);
        wr(8'h7b, 8'h04);
        step(16'hffff, 12'h006, 12'h004);
        @(posedge clock_i);
        host_lvl <= 12'h5a3;
        repeat (3) @(posedge clock_i);
        rd(8'h7d, 8'ha5);
        rd(8'h7e, 8'h05);
    endtask
    task automatic t_bc;
        wr(8'h6f, 8'h1b);
        wr(8'h71, 8'h20);
        wr(8'h74, 8'h00);
        wr(8'h75, 8'h55);
        wr(8'h76, 8'h99);
        wr(8'h77, 8'haa);
        step(16'h0620, 12'hfc0, 12'hfc0);
        wr(8'h71, 8'h01);
        step(16'h0620, 12'hcf0, 12'hcc0);
    endtask
    // C0 as driven GPIO, then a frozen write and frozen flags must not show
    task automatic t_hold;
        wr(8'h7a, 8'h01);
        wr(8'h7c, 8'h01);
        step(16'h0620, 12'hdf0, 12'hdc0);
        @(posedge clock_i);
        clk_en <= 1'b0;
        wr(8'h7c, 8'h00);
        step(16'h0000, 12'hdf0, 12'hdc0);
        @(posedge clock_i);
        clk_en <= 1'b1;
        step(16'h0620, 12'hdf0, 12'hdc0);
        rd(8'h7c, 8'h01);
    endtask
    task automatic wrap_up;
        if (err_total == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Generous ceiling; the sequence needs well under 1000 cycles
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            wrap_up();
        end
    end
    initial begin
        repeat (3) @(posedge clock_i);
        reset_n_i <= 1'b1;
        #1;
        t_defaults();
        t_flags();
        t_gpio();
        t_bc();
        t_hold();
        wrap_up();
    end
endmodule // pin_mux_tb_top
